// ==== pkg/stepper_pkg.sv ====
// constants, layouts and types shared by the step indexer design
// assumes a single 10 MHz clock and an apb register port with 32-bit data
package stepper_pkg;

    // clock rate and time figures
    localparam int CLOCK_HZ = 10000000;
    localparam int SLEEP_DELAY_US = 100;
    localparam int WAKE_MAX_MS = 10;
    // sleep entry is an exact delay, rounded up to whole cycles
    localparam int SLEEP_DELAY_CYCLES =
        (SLEEP_DELAY_US * (CLOCK_HZ / 1000) + 999) / 1000;
    // wake-up is a longest time, rounded down
    localparam int WAKE_CYCLES = WAKE_MAX_MS * (CLOCK_HZ / 1000);
    // pin edge to state change: three sync stages, filter, edge logic
    localparam int PIN_LATENCY = 5;

    // electrical angle index, 1/32 step units, 128 per cycle
    localparam int INDEX_W = 7;
    localparam logic [6:0] INDEX_HOME_FINE = 7'h00;
    localparam logic [6:0] INDEX_HOME_FULL = 7'h10;
    localparam logic [4:0] INDEX_MID_QUARTER = 5'h10;

    // resolution codes, bit 2 = select 0, bit 0 = select 2
    localparam logic [2:0] RES_FULL = 3'h0;
    localparam logic [2:0] RES_HALF_A = 3'h1;
    localparam logic [2:0] RES_HALF_B = 3'h2;
    localparam logic [2:0] RES_QUARTER = 3'h3;
    localparam logic [2:0] RES_EIGHTH = 3'h4;
    localparam logic [2:0] RES_SIXTEENTH = 3'h5;

    // stride of one step at each resolution
    localparam logic [6:0] STRIDE_FULL = 7'h20;
    localparam logic [6:0] STRIDE_HALF = 7'h10;
    localparam logic [6:0] STRIDE_QUARTER = 7'h08;
    localparam logic [6:0] STRIDE_EIGHTH = 7'h04;
    localparam logic [6:0] STRIDE_SIXTEENTH = 7'h02;
    localparam logic [6:0] STRIDE_FINEST = 7'h01;

    // current levels in percent
    localparam logic [7:0] CURRENT_FULL_PCT = 8'h64;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CURRENT = 8'h08;
    localparam int CTRL_HOME_BIT = 0;
    localparam int CTRL_INHIBIT_BIT = 1;
    localparam logic CTRL_INHIBIT_RESET = 1'b0;

    // power sequencing states
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_SLEEP_PEND = 4'h2,
        ST_ASLEEP = 4'h4,
        ST_WAKING = 4'h8
    } power_state_t;

    // host pins as one bundle
    typedef struct packed {
        logic step;
        logic direction_select;
        logic [2:0] resolution;
        logic enable;
        logic sleep_n;
        logic angle_reset;
        logic thermal_shutdown;
        logic overcurrent_detect;
    } pins_t;

    // pin levels assumed at reset: awake, everything else low
    localparam pins_t PINS_RESET = '{
        step: 1'b0, direction_select: 1'b0, resolution: 3'h0,
        enable: 1'b0, sleep_n: 1'b1, angle_reset: 1'b0,
        thermal_shutdown: 1'b0, overcurrent_detect: 1'b0};

    // status register layout
    typedef struct packed {
        logic [13:0] zero;
        power_state_t state;
        logic [2:0] resolution;
        logic outputs_on;
        logic fault_2;
        logic fault_1;
        logic monitor;
        logic [6:0] index;
    } status_t;

endpackage

// ==== rtl/pin_sync.sv ====
// three-stage synchroniser with agreement filter for a bundle of pins
// assumes pins are asynchronous to clock_in; reset is synchronous
`timescale 1ns/1ns
module pin_sync
    import stepper_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
        logic [WIDTH-1:0] third;
        logic [WIDTH-1:0] level;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // first stage only feeds the second; level follows when 2 and 3 agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.first = pins_in;
        s_nxt.second = s_r.first;
        s_nxt.third = s_r.second;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_r.second[i] == s_r.third[i]) begin
                s_nxt.level[i] = s_r.third[i];
            end
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_r <= '{first: INIT, second: INIT, third: INIT, level: INIT};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_out = s_r.level;
endmodule

// ==== rtl/phase_current_table.sv ====
// sine and cosine current lookup for both phases from the angle index
// assumes a 7-bit index in 1/32 step units, purely combinational
`timescale 1ns/1ns
module phase_current_table
    import stepper_pkg::*;
(
    input wire logic [6:0] index_in,
    input wire logic boost_in,
    output logic signed [7:0] phase_a_out,
    output logic signed [7:0] phase_b_out
);
    // magnitude of sin(k * 90 / 32 degrees) in percent, k = 0..31
    localparam logic [7:0] SINE_PCT [32] = '{
        8'h00, 8'h05, 8'h0a, 8'h0f, 8'h14, 8'h18, 8'h1d, 8'h22,
        8'h26, 8'h2b, 8'h2f, 8'h33, 8'h38, 8'h3c, 8'h3f, 8'h43,
        8'h47, 8'h4a, 8'h4d, 8'h50, 8'h53, 8'h56, 8'h58, 8'h5a,
        8'h5c, 8'h5e, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h64};

    // lookup; the quarter point k = 32 is full current
    function automatic logic [7:0] sine_pct(input logic [5:0] k);
        logic [7:0] v;
        v = CURRENT_FULL_PCT;
        if (k < 6'h20) begin
            v = SINE_PCT[k[4:0]];
        end
        return v;
    endfunction

    logic [5:0] k;
    logic [5:0] k_rev;
    logic [7:0] sin_mag;
    logic [7:0] cos_mag;

    // quadrant split; mid-quadrant boosted to full in full and half a modes
    always_comb begin
        k = {1'b0, index_in[4:0]};
        k_rev = 6'h20 - k;
        sin_mag = sine_pct(k);
        cos_mag = sine_pct(k_rev);
        if (boost_in && index_in[4:0] == INDEX_MID_QUARTER) begin
            sin_mag = CURRENT_FULL_PCT;
            cos_mag = CURRENT_FULL_PCT;
        end
        case (index_in[6:5])
            2'h0: begin
                phase_a_out = $signed(cos_mag);
                phase_b_out = $signed(sin_mag);
            end
            2'h1: begin
                phase_a_out = -$signed(sin_mag);
                phase_b_out = $signed(cos_mag);
            end
            2'h2: begin
                phase_a_out = -$signed(cos_mag);
                phase_b_out = -$signed(sin_mag);
            end
            default: begin
                phase_a_out = $signed(sin_mag);
                phase_b_out = -$signed(cos_mag);
            end
        endcase
    end
endmodule

// ==== rtl/stepper_step_indexer.sv ====
// control logic of a two-phase stepping motor driver in clock-input mode
// assumes host pins are asynchronous and software uses an apb master
`timescale 1ns/1ns

// Notes on behaviour
// - While the angle reset input is high the index is held at home.
// - Each rising step edge while awake and not inhibited moves the index by one step of the resolution.
// - A falling step edge changes neither the index nor the currents.
// - Sleep request low puts the device to sleep 100 us later.
// - After sleep request returns high, normal operation is back in 10 ms.
// - A shutdown fault keeps the outputs off until one sleep and wake cycle.
// - Enable high switches the bridge on under normal current control.
// - Enable low switches the bridge off and leaves the outputs floating.
// - Direction high steps the index forward, low steps it backward.
// - The three resolution inputs pick full, half a/b, 1/4, 1/8, 1/16, 1/32.
// - Two fault flags report detected thermal or over-current errors.
// - Phase currents follow a sine/cosine table in 1/32 steps.
module stepper_step_indexer
    import stepper_pkg::*;
#(
    parameter int WAKE_CYCLES_P = WAKE_CYCLES,
    parameter int SLEEP_CYCLES_P = SLEEP_DELAY_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic step_in,
    input wire logic direction_select_in,
    input wire logic resolution_select_0_in,
    input wire logic resolution_select_1_in,
    input wire logic resolution_select_2_in,
    input wire logic enable_in,
    input wire logic sleep_n_in,
    input wire logic angle_reset_in,
    input wire logic thermal_shutdown_in,
    input wire logic overcurrent_detect_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic signed [7:0] phase_a_current_out,
    output logic signed [7:0] phase_b_current_out,
    output logic outputs_on_out,
    output logic supply_on_out,
    output logic normal_mode_out,
    output logic fault_flag_1_out,
    output logic fault_flag_2_out,
    output logic angle_monitor_out
);
    // counter limits, trimmed by the pin synchroniser latency
    localparam int WAKE_LIMIT = WAKE_CYCLES_P - PIN_LATENCY;
    localparam int SLEEP_LIMIT = SLEEP_CYCLES_P - PIN_LATENCY;
    localparam int CNT_W = $clog2(WAKE_CYCLES_P + SLEEP_CYCLES_P + 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_LIMIT - 1);
    localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_LIMIT - 1);

    // whole state of the block
    typedef struct packed {
        logic step_q;
        logic [6:0] index;
        power_state_t pstate;
        logic [CNT_W-1:0] count;
        logic fault_thermal;
        logic fault_overcurrent;
        logic inhibit;
        logic outputs_on;
        logic signed [7:0] phase_a;
        logic signed [7:0] phase_b;
        logic [31:0] prdata;
        logic pslverr;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;

    pins_t pins_raw;
    pins_t pins;
    logic signed [7:0] table_a;
    logic signed [7:0] table_b;
    logic [6:0] home;
    logic [6:0] stride;
    logic boost;
    logic step_rise;
    logic logic_awake;
    logic wake_done;
    logic apb_setup;
    logic apb_access;
    logic home_write;
    status_t status;

    // step size per resolution code
    function automatic logic [6:0] stride_of(input logic [2:0] res);
        logic [6:0] v;
        v = STRIDE_FINEST;
        case (res)
            RES_FULL: v = STRIDE_FULL;
            RES_HALF_A: v = STRIDE_HALF;
            RES_HALF_B: v = STRIDE_HALF;
            RES_QUARTER: v = STRIDE_QUARTER;
            RES_EIGHTH: v = STRIDE_EIGHTH;
            RES_SIXTEENTH: v = STRIDE_SIXTEENTH;
            default: v = STRIDE_FINEST;
        endcase
        return v;
    endfunction

    // home position: full step rests on the both-phases point
    function automatic logic [6:0] home_of(input logic [2:0] res);
        logic [6:0] v;
        v = INDEX_HOME_FINE;
        if (res == RES_FULL) begin
            v = INDEX_HOME_FULL;
        end
        return v;
    endfunction

    // pins into the clock domain as one bundle
    always_comb begin
        pins_raw.step = step_in;
        pins_raw.direction_select = direction_select_in;
        pins_raw.resolution = {resolution_select_0_in,
                               resolution_select_1_in,
                               resolution_select_2_in};
        pins_raw.enable = enable_in;
        pins_raw.sleep_n = sleep_n_in;
        pins_raw.angle_reset = angle_reset_in;
        pins_raw.thermal_shutdown = thermal_shutdown_in;
        pins_raw.overcurrent_detect = overcurrent_detect_in;
    end

    pin_sync #(
        .WIDTH($bits(pins_t)),
        .INIT(PINS_RESET)
    ) u_pin_sync (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .pins_in(pins_raw),
        .level_out(pins)
    );

    // current lookup from the present index
    phase_current_table u_table (
        .index_in(s_r.index),
        .boost_in(boost),
        .phase_a_out(table_a),
        .phase_b_out(table_b)
    );

    // decode of mode, edges and bus phases
    always_comb begin
        stride = stride_of(pins.resolution);
        home = home_of(pins.resolution);
        boost = (pins.resolution == RES_FULL) ||
                (pins.resolution == RES_HALF_A);
        step_rise = pins.step && !s_r.step_q;
        logic_awake = (s_r.pstate == ST_ACTIVE) ||
                      (s_r.pstate == ST_SLEEP_PEND);
        apb_setup = psel_in && !penable_in;
        apb_access = psel_in && penable_in;
        home_write = apb_access && pwrite_in && paddr_in == REG_CTRL &&
                     pwdata_in[CTRL_HOME_BIT];
        wake_done = (s_r.pstate == ST_WAKING) && pins.sleep_n &&
                    (s_r.count == WAKE_LAST);
    end

    // status word as software sees it
    always_comb begin
        status = '0;
        status.state = s_r.pstate;
        status.resolution = pins.resolution;
        status.outputs_on = s_r.outputs_on;
        status.fault_2 = s_r.fault_overcurrent;
        status.fault_1 = s_r.fault_thermal;
        status.monitor = (s_r.index == home);
        status.index = s_r.index;
    end

    // next state of the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.step_q = pins.step;

        // power sequencing
        case (s_r.pstate)
            ST_ACTIVE: begin
                if (!pins.sleep_n) begin
                    s_nxt.pstate = ST_SLEEP_PEND;
                    s_nxt.count = '0;
                end
            end
            ST_SLEEP_PEND: begin
                if (pins.sleep_n) begin
                    s_nxt.pstate = ST_ACTIVE;
                end else if (s_r.count == SLEEP_LAST) begin
                    s_nxt.pstate = ST_ASLEEP;
                end else begin
                    s_nxt.count = s_r.count + 1'b1;
                end
            end
            ST_ASLEEP: begin
                if (pins.sleep_n) begin
                    s_nxt.pstate = ST_WAKING;
                    s_nxt.count = '0;
                end
            end
            ST_WAKING: begin
                if (!pins.sleep_n) begin
                    s_nxt.pstate = ST_ASLEEP;
                end else if (wake_done) begin
                    s_nxt.pstate = ST_ACTIVE;
                end else begin
                    s_nxt.count = s_r.count + 1'b1;
                end
            end
            default: begin
                s_nxt.pstate = ST_ACTIVE;
            end
        endcase

        // shutdown latches: a new fault wins over the wake-up clear
        s_nxt.fault_thermal = pins.thermal_shutdown ||
                              (s_r.fault_thermal && !wake_done);
        s_nxt.fault_overcurrent = pins.overcurrent_detect ||
                                  (s_r.fault_overcurrent && !wake_done);

        // angle index: reset pin or software home first, then steps
        if (pins.angle_reset || home_write) begin
            s_nxt.index = home;
        end else if (step_rise && logic_awake && !s_r.inhibit) begin
            if (pins.direction_select) begin
                s_nxt.index = s_r.index + stride;
            end else begin
                s_nxt.index = s_r.index - stride;
            end
        end

        // bridge on only when enabled, awake and free of faults
        s_nxt.outputs_on = pins.enable && logic_awake &&
                           !s_nxt.fault_thermal &&
                           !s_nxt.fault_overcurrent;

        // current references track the index, one cycle behind
        s_nxt.phase_a = table_a;
        s_nxt.phase_b = table_b;

        // apb: read data and error prepared in the setup cycle
        if (apb_setup) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = '0;
            case (paddr_in)
                REG_CTRL: begin
                    s_nxt.prdata[CTRL_INHIBIT_BIT] = s_r.inhibit;
                end
                REG_STATUS: begin
                    s_nxt.prdata = status;
                end
                REG_CURRENT: begin
                    s_nxt.prdata[15:0] = {s_r.phase_b, s_r.phase_a};
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // apb write takes effect at the access edge
        if (apb_access && pwrite_in && paddr_in == REG_CTRL) begin
            s_nxt.inhibit = pwdata_in[CTRL_INHIBIT_BIT];
        end
    end

    // state register
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_r <= '{
                step_q: 1'b0,
                index: INDEX_HOME_FINE,
                pstate: ST_ACTIVE,
                count: '0,
                fault_thermal: 1'b0,
                fault_overcurrent: 1'b0,
                inhibit: CTRL_INHIBIT_RESET,
                outputs_on: 1'b0,
                phase_a: '0,
                phase_b: '0,
                prdata: '0,
                pslverr: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // apb answers with no wait state
    assign pready_out = apb_access;
    assign pslverr_out = apb_access && s_r.pslverr;
    assign prdata_out = s_r.prdata;

    // motor-side outputs
    assign phase_a_current_out = s_r.phase_a;
    assign phase_b_current_out = s_r.phase_b;
    assign outputs_on_out = s_r.outputs_on;
    assign supply_on_out = (s_r.pstate != ST_ASLEEP);
    assign normal_mode_out = (s_r.pstate == ST_ACTIVE);
    assign fault_flag_1_out = s_r.fault_thermal;
    assign fault_flag_2_out = s_r.fault_overcurrent;
    assign angle_monitor_out = (s_r.index == home);
endmodule

// ==== test/stepper_props.sv ====
// concurrent checks on the step indexer top-level ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ns
module stepper_props #(
    parameter int WAKE_CYCLES_P = 40,
    parameter int SLEEP_CYCLES_P = 20
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic sleep_n_in,
    input wire logic angle_reset_in,
    input wire logic thermal_shutdown_in,
    input wire logic overcurrent_detect_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic outputs_on_out,
    input wire logic supply_on_out,
    input wire logic normal_mode_out,
    input wire logic fault_flag_1_out,
    input wire logic fault_flag_2_out,
    input wire logic angle_monitor_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic [15:0] lo_cnt_r, hi_cnt_r;
    // cycles the sleep request has been low, and high
    always_ff @(posedge clock_in) begin
        if (reset_in || sleep_n_in) lo_cnt_r <= '0;
        else if (lo_cnt_r != 16'hffff) lo_cnt_r <= lo_cnt_r + 16'h1;
        if (reset_in || !sleep_n_in) hi_cnt_r <= '0;
        else if (hi_cnt_r != 16'hffff) hi_cnt_r <= hi_cnt_r + 16'h1;
    end
    sequence s_access;
        psel_in && penable_in;
    endsequence
    sequence s_fault_held;
        (fault_flag_1_out || fault_flag_2_out) [*3];
    endsequence
    a_ready_no_wait: assert property (s_access |-> pready_out)
        else $error("access cycle without ready");
    a_bad_addr_err: assert property (s_access and
        !(paddr_in inside {8'h00, 8'h04, 8'h08})
        |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    a_bridge_on: assert property ((enable_in && normal_mode_out
        && !fault_flag_1_out && !fault_flag_2_out) [*6] |-> outputs_on_out)
        else $error("bridge off while enabled");
    a_bridge_off: assert property (!enable_in [*6] |-> !outputs_on_out)
        else $error("bridge on while disabled");
    a_fault_off: assert property (s_fault_held |-> !outputs_on_out)
        else $error("bridge on during fault");
    a_thermal_flag: assert property (thermal_shutdown_in [*6]
        |-> fault_flag_1_out) else $error("thermal flag missing");
    a_over_flag: assert property (overcurrent_detect_in [*6]
        |-> fault_flag_2_out) else $error("overcurrent flag missing");
    a_fault_clear: assert property ($fell(fault_flag_1_out)
        |-> $rose(normal_mode_out) || $past(reset_in))
        else $error("fault cleared without wake");
    a_sleep_delay: assert property ($fell(supply_on_out)
        |-> lo_cnt_r >= SLEEP_CYCLES_P - 2 && lo_cnt_r <= SLEEP_CYCLES_P + 3)
        else $error("sleep entry at wrong time");
    a_wake_bound: assert property (hi_cnt_r == WAKE_CYCLES_P + 8
        |-> normal_mode_out) else $error("wake took too long");
    a_home_monitor: assert property (angle_reset_in [*8]
        |-> angle_monitor_out) else $error("monitor low at home");
endmodule
bind stepper_step_indexer stepper_props #(.WAKE_CYCLES_P(WAKE_CYCLES_P),
    .SLEEP_CYCLES_P(SLEEP_CYCLES_P)) props (.clock_in(clock_in),
    .reset_in(reset_in), .enable_in(enable_in), .sleep_n_in(sleep_n_in),
    .angle_reset_in(angle_reset_in), .psel_in(psel_in),
    .thermal_shutdown_in(thermal_shutdown_in), .paddr_in(paddr_in),
    .overcurrent_detect_in(overcurrent_detect_in),
    .penable_in(penable_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .outputs_on_out(outputs_on_out), .supply_on_out(supply_on_out),
    .normal_mode_out(normal_mode_out), .fault_flag_1_out(fault_flag_1_out),
    .fault_flag_2_out(fault_flag_2_out),
    .angle_monitor_out(angle_monitor_out));

// ==== test/host_pins_model.sv ====
// host controller model driving the step and control pins
// assumes pins change by non-blocking assignment after a rising edge
`timescale 1ns/1ns
module host_pins_model
    import stepper_pkg::*;
(
    input wire logic clock_in,
    output pins_t pins_out
);
    initial pins_out = PINS_RESET;
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // step pulses, high and low each longer than the filter
    task automatic pulse_step(input int n);
        repeat (n) begin
            @(posedge clock_in);
            pins_out.step <= 1'b1;
            wait_cycles(4);
            pins_out.step <= 1'b0;
            wait_cycles(3);
        end
    endtask
    task automatic set_step(input logic v);
        @(posedge clock_in);
        pins_out.step <= v;
        wait_cycles(6);
    endtask
    task automatic set_mode(input logic [2:0] res, input logic dir);
        @(posedge clock_in);
        pins_out.resolution <= res;
        pins_out.direction_select <= dir;
        wait_cycles(6);
    endtask
    // angle reset pulse back to home
    task automatic home();
        @(posedge clock_in);
        pins_out.angle_reset <= 1'b1;
        wait_cycles(9);
        pins_out.angle_reset <= 1'b0;
        wait_cycles(6);
    endtask
    task automatic set_levels(input logic en, th, oc);
        @(posedge clock_in);
        pins_out.enable <= en;
        pins_out.thermal_shutdown <= th;
        pins_out.overcurrent_detect <= oc;
        wait_cycles(10);
    endtask
    // one sleep entry then the sleep request back high for hi cycles
    task automatic sleep_cycle(input int lo, input int hi);
        @(posedge clock_in);
        pins_out.sleep_n <= 1'b0;
        wait_cycles(lo);
        pins_out.sleep_n <= 1'b1;
        wait_cycles(hi);
    endtask
endmodule

// ==== test/tb_top.sv ====
// self-checking bench: apb register reads plus host pin sequences
// assumes the pin model and the bound property checker
`timescale 1ns/1ns
module tb_top;
    import stepper_pkg::*;
    localparam int SLP = 20;
    localparam int WAK = 40;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, on, supply, normal, f1, f2, mon;
    logic signed [7:0] cur_a, cur_b;
    logic [6:0] hm;
    pins_t pins;
    status_t st;
    int err_total = 0, checks = 0, cyc = 0;
    int stride[8] = '{32, 16, 16, 8, 4, 2, 1, 1};
    always #50 clock_in = ~clock_in;
    host_pins_model host (.clock_in(clock_in), .pins_out(pins));
    stepper_step_indexer #(.WAKE_CYCLES_P(WAK), .SLEEP_CYCLES_P(SLP)) dut (
        .clock_in(clock_in), .reset_in(reset_in), .step_in(pins.step),
        .direction_select_in(pins.direction_select),
        .resolution_select_0_in(pins.resolution[2]),
        .resolution_select_1_in(pins.resolution[1]),
        .resolution_select_2_in(pins.resolution[0]),
        .enable_in(pins.enable), .sleep_n_in(pins.sleep_n),
        .angle_reset_in(pins.angle_reset),
        .thermal_shutdown_in(pins.thermal_shutdown),
        .overcurrent_detect_in(pins.overcurrent_detect), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .phase_a_current_out(cur_a),
        .phase_b_current_out(cur_b), .outputs_on_out(on),
        .supply_on_out(supply), .normal_mode_out(normal),
        .fault_flag_1_out(f1), .fault_flag_2_out(f2),
        .angle_monitor_out(mon));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_index(string name, logic [6:0] exp);
        apb(1'b0, REG_STATUS, 32'h0);
        st = status_t'(rd);
        check(name, 32'(st.index), 32'(exp));
    endtask
    // hang guard
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        // every resolution code: home, one step forward, two back
        for (int c = 0; c < 8; c++) begin
            hm = (c == 0) ? 7'h10 : 7'h00;
            host.set_mode(3'(c), 1'b1);
            host.home();
            check_index("home", hm);
            check("monitor", 32'(mon), 32'h1);
            apb(1'b0, REG_CURRENT, 32'h0);
            check("home cur", rd, (c == 0) ? 32'h6464 : 32'h0064);
            host.pulse_step(1);
            check_index("fwd", hm + 7'(stride[c]));
            host.set_mode(3'(c), 1'b0);
            host.pulse_step(2);
            check_index("rev", hm - 7'(stride[c]));
        end
        // 1/32 mode: rise counts, fall holds, currents at 71 percent
        host.home();
        host.pulse_step(15);
        host.set_step(1'b1);
        check_index("rise", 7'h70);
        host.set_step(1'b0);
        check_index("fall", 7'h70);
        host.set_mode(3'h6, 1'b1);
        host.pulse_step(32);
        apb(1'b0, REG_CURRENT, 32'h0);
        check("cur 16", rd, 32'h4747);
        check("cur pins", {16'h0, cur_b, cur_a}, 32'h4747);
        // inhibit and home through ctrl, step ignored
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", rd, 32'h2);
        host.pulse_step(1);
        check_index("inhib", 7'h00);
        apb(1'b1, REG_CTRL, 32'h0);
        host.set_levels(1'b1, 1'b0, 1'b0);
        check("on", 32'(on), 32'h1);
        host.set_levels(1'b0, 1'b0, 1'b0);
        check("off", 32'(on), 32'h0);
        // faults latch and hold the bridge off until a sleep cycle
        host.set_levels(1'b1, 1'b1, 1'b1);
        host.set_levels(1'b1, 1'b0, 1'b0);
        check("flags", {30'h0, f2, f1}, 32'h3);
        check("fault off", 32'(on), 32'h0);
        host.sleep_cycle(SLP + 8, 2);
        check("asleep", {30'h0, supply, on}, 32'h0);
        host.wait_cycles(WAK + 8);
        check("awake", 32'(normal), 32'h1);
        check("cleared", {29'h0, f2, f1, on}, 32'h1);
        print_verdict();
    end
endmodule
